// ### core/zoom_lo_fifo.sv
`timescale 1ns/1ps
module zoom_lo_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  // Honest flags straight from the occupancy count
  assign in_ready = (count_reg != AW'(0) + (AW+1)'(DEPTH)) ;
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rd_ptr_reg];
  assign push = in_valid && in_ready && clk_en;
  assign pop = out_valid && out_ready && clk_en;

  // Storage array
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

// ### core/zoom_lo_frequency_control.sv
`timescale 1ns/1ps
//
// Contract
// R1: Centre frequency is a signed fraction of fs, from -0.5 to +0.5.
// R2: Frequency changes keep LO phase continuous, except changes to zero.
// R3: Complex-baseband off and change to zero resets LO phase to zero.
// R4: Complex-baseband on and change to zero leaves LO phase untouched.
// R5: Complex-baseband option ignored when target frequency is nonzero.
// R6: Sync mode off: written frequency takes effect immediately.
// R7: Sync mode on: frequency held pending until the next SYNC assertion.
// R8: Clearing sync mode with a change pending applies it at once.
// R9: Requested frequency quantised to the nearest tuning word step.
// R10: Readback gives quantised value, or pending value while awaiting SYNC.
// R11: Negative frequency selects negative image, inverting the spectrum.
// R12: Reset clears complex-baseband, sync mode, and frequency to zero.
// R13: Writing frequency or mode settings never aborts a measurement.
// R14: Offset calibration aborts measurement and loses LO coherence.
// R15: Raw path sets frequency from coarse fs/2048 plus fine fs/1.024e12.
// R16: Phase accumulator advances by tuning word each clock; samples mixed. The code holds the phase while calibration runs.
module zoom_lo_frequency_control
  import zoom_lo_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic sync_pin,
  input wire logic meas_active,
  input wire logic [SAMPLE_W-1:0] sample_in,
  input wire logic sample_valid,
  output logic sample_ready,
  output logic [2*SAMPLE_W-1:0] bb_data,
  output logic bb_valid,
  input wire logic bb_ready,
  output logic meas_abort,
  output logic lo_coherent
);
  logic cmplx_reg;
  logic sync_mode_reg;
  logic pending_reg;
  logic [TUNE_W-1:0] freq_pend_reg;
  logic [TUNE_W-1:0] freq_act_reg;
  logic [TUNE_W-1:0] phase_reg;
  logic [7:0] freq_lo_hold_reg;
  logic [COARSE_W-1:0] coarse_reg;
  logic sync_ff1_reg;
  logic sync_ff2_reg;
  logic sync_prev_reg;
  logic sync_rise;
  logic [$clog2(CAL_CYCLES):0] cal_cnt_reg;
  logic cal_busy;
  logic abort_reg;
  logic coh_reg;
  logic wr_freq;
  logic [TUNE_W-1:0] wr_word;
  logic [TUNE_W-1:0] fine_word;
  logic apply_now;
  logic [TUNE_W-1:0] apply_word;
  logic [SAMPLE_W-1:0] cos_val;
  logic [SAMPLE_W-1:0] sin_val;
  logic signed [2*SAMPLE_W-1:0] prod_i;
  logic signed [2*SAMPLE_W-1:0] prod_q;
  logic fifo_in_ready;
  logic [2*SAMPLE_W-1:0] fifo_out_data;
  logic fifo_out_valid;
  logic out_take;
  logic cal_start;
  logic fifo_push;
  logic fifo_pop;
  logic [$clog2(FIFO_DEPTH):0] fill_reg;
  logic [$clog2(FIFO_DEPTH):0] fill_next;
  logic signed [47:0] fine_ext;
  logic signed [47:0] fine_prod;
  logic [TUNE_W-1:0] coarse_word;

  // SYNC pin from the shared backplane line: two flops before use
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync_ff1_reg <= 1'b0;
      sync_ff2_reg <= 1'b0;
      sync_prev_reg <= 1'b0;
    end else if (clk_en) begin
      sync_ff1_reg <= sync_pin;
      sync_ff2_reg <= sync_ff1_reg;
      sync_prev_reg <= sync_ff2_reg;
    end
  end
  assign sync_rise = sync_ff2_reg && !sync_prev_reg;

  // Fine term is signed; widen first so fine * FINE_MUL cannot wrap before the shift
  assign fine_ext = {{16{reg_wdata[31]}}, reg_wdata};
  assign fine_prod = fine_ext * $signed(48'(FINE_MUL));
  // Half a step is added before the shift so the word rounds to the nearest step
  assign fine_word = TUNE_W'((fine_prod + $signed(48'(1) << (FINE_SHIFT - 1))) >>> FINE_SHIFT);
  // Coarse term in fs/2048 units; bits above the word alias, as +-fs/2 wraps anyway
  assign coarse_word = {coarse_reg[TUNE_W-COARSE_SHIFT-1:0], {COARSE_SHIFT{1'b0}}};

  // Frequency write decode; signed word wraps so 0.5 and -0.5 alias, range is +-fs/2
  always_comb begin
    wr_freq = 1'b0;
    wr_word = freq_pend_reg;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_FREQ_HI: begin
          wr_freq = 1'b1; // R1 R9
          wr_word = {reg_wdata[31:0], freq_lo_hold_reg};
        end
        ADDR_RAW_FINE: begin
          wr_freq = 1'b1; // R15
          // The fine write commits coarse plus fine as one word
          wr_word = coarse_word + fine_word;
        end
        default: begin
          wr_freq = 1'b0;
        end
      endcase
    end
  end

  // Raw coarse term and low byte staging
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      coarse_reg <= '0;
      freq_lo_hold_reg <= 8'h0;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == ADDR_RAW_COARSE) begin
        coarse_reg <= reg_wdata[COARSE_W-1:0];
      end
      if (reg_addr == ADDR_FREQ_LO) begin
        freq_lo_hold_reg <= reg_wdata[7:0];
      end
    end
  end

  // Mode bits; writing them touches no measurement state
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmplx_reg <= 1'b0; // R12
      sync_mode_reg <= 1'b0; // R12
    end else if (clk_en && reg_wr && reg_addr == ADDR_CTRL) begin
      cmplx_reg <= reg_wdata[CTRL_CMPLX_BIT]; // R13
      sync_mode_reg <= reg_wdata[CTRL_SYNC_BIT];
    end
  end

  // Decide when the pending word reaches the oscillator
  always_comb begin
    apply_now = 1'b0;
    apply_word = freq_pend_reg;
    if (wr_freq && !sync_mode_reg) begin
      apply_now = 1'b1; // R6
      apply_word = wr_word;
    end else if (pending_reg && sync_rise && sync_mode_reg) begin
      apply_now = 1'b1; // R7
    end else if (pending_reg && reg_wr && reg_addr == ADDR_CTRL && !reg_wdata[CTRL_SYNC_BIT]) begin
      apply_now = 1'b1; // R8
    end
  end

  // Pending word, held for readback, and active word
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      freq_pend_reg <= FREQ_RESET; // R12
      freq_act_reg <= FREQ_RESET;
      pending_reg <= 1'b0;
    end else if (clk_en) begin
      if (wr_freq) begin
        freq_pend_reg <= wr_word; // R10
      end
      if (apply_now) begin
        freq_act_reg <= apply_word;
      end
      // A new write in sync mode re-arms; a write racing SYNC stays pending
      if (wr_freq && sync_mode_reg) begin
        pending_reg <= 1'b1; // R7
      end else if (apply_now) begin
        pending_reg <= 1'b0;
      end
    end
  end

  // Phase accumulator; a change to zero resets phase unless complex-baseband is set
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_reg <= '0;
    end else if (clk_en) begin
      if (apply_now && apply_word == '0 && freq_act_reg != '0 && !cmplx_reg) begin
        phase_reg <= '0; // R3
      end else if (apply_now && apply_word == '0) begin
        phase_reg <= phase_reg; // R4
      end else if (!cal_busy) begin
        phase_reg <= phase_reg + freq_act_reg; // R2 R5 R16
      end
    end
  end

  // Coarse quarter-wave phasor from the top phase bits; negative words spin backwards
  always_comb begin
    case (phase_reg[TUNE_W-1 -: 2])
      2'b00: begin
        cos_val = 16'h7fff;
        sin_val = 16'h0000;
      end
      2'b01: begin
        cos_val = 16'h0000;
        sin_val = 16'h7fff;
      end
      2'b10: begin
        cos_val = 16'h8001;
        sin_val = 16'h0000;
      end
      default: begin
        cos_val = 16'h0000;
        sin_val = 16'h8001;
      end
    endcase
  end

  // Mix down by e^-jwt; sign of word picks the image, inverting the spectrum
  assign prod_i = $signed(sample_in) * $signed(cos_val); // R11 R16
  assign prod_q = -($signed(sample_in) * $signed(sin_val));

  // Calibration start on the register port
  assign cal_start = reg_wr && reg_addr == ADDR_CTRL && reg_wdata[CTRL_CAL_BIT];

  // Offset calibration: runs a fixed time, stalls the path, drops coherence
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cal_cnt_reg <= '0;
      abort_reg <= 1'b0;
      coh_reg <= 1'b1;
    end else if (clk_en) begin
      abort_reg <= 1'b0;
      if (cal_start) begin
        cal_cnt_reg <= ($clog2(CAL_CYCLES)+1)'(CAL_CYCLES);
        abort_reg <= meas_active; // R14
        coh_reg <= 1'b0; // R14
      end else if (cal_cnt_reg != '0) begin
        cal_cnt_reg <= cal_cnt_reg - 1'b1;
      end
      // Coherence returns only when SYNC realigns the oscillator; a calibration
      // starting in the same cycle wins, since it breaks the alignment again
      if (!cal_busy && !cal_start && sync_rise && apply_now) begin
        coh_reg <= 1'b1;
      end
    end
  end
  assign cal_busy = (cal_cnt_reg != '0);

  // Mirror of the FIFO fill, so ready can look one word ahead
  assign fifo_push = sample_valid && sample_ready && fifo_in_ready;
  assign fifo_pop = fifo_out_valid && out_take;
  always_comb begin
    fill_next = fill_reg;
    if (fifo_push && !fifo_pop) begin
      fill_next = fill_reg + 1'b1;
    end else if (fifo_pop && !fifo_push) begin
      fill_next = fill_reg - 1'b1;
    end
  end

  // Fill tracker, stepped exactly like the FIFO's own count
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fill_reg <= '0;
    end else if (clk_en) begin
      fill_reg <= fill_next;
    end
  end

  // Ready is a flop, so it is raised only when the FIFO will still have room at the
  // next edge; a sample offered while ready is high is never dropped
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sample_ready <= 1'b0;
    end else if (clk_en) begin
      sample_ready <= (fill_next != ($clog2(FIFO_DEPTH)+1)'(FIFO_DEPTH)) && !cal_busy
                      && !cal_start; // R14
    end
  end

  zoom_lo_fifo #(
    .WIDTH(2*SAMPLE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .in_valid(sample_valid && sample_ready),
    .in_ready(fifo_in_ready),
    .in_data({prod_i[2*SAMPLE_W-2 -: SAMPLE_W], prod_q[2*SAMPLE_W-2 -: SAMPLE_W]}),
    .out_valid(fifo_out_valid),
    .out_ready(out_take),
    .out_data(fifo_out_data)
  );

  // Output skid: register holds a word until the consumer takes it
  assign out_take = !bb_valid || bb_ready;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bb_valid <= 1'b0;
      bb_data <= '0;
    end else if (clk_en && out_take) begin
      bb_valid <= fifo_out_valid;
      bb_data <= fifo_out_data;
    end
  end

  // Status outputs
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meas_abort <= 1'b0;
      lo_coherent <= 1'b1;
    end else if (clk_en) begin
      meas_abort <= abort_reg;
      lo_coherent <= coh_reg;
    end
  end

  // Register readback, one cycle after the read strobe
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0;
    end else if (clk_en) begin
      reg_rdata <= 32'h0;
      if (reg_rd) begin
        case (reg_addr)
          ADDR_CTRL: reg_rdata <= {30'h0, sync_mode_reg, cmplx_reg};
          ADDR_FREQ_LO: reg_rdata <= {24'h0, freq_pend_reg[7:0]}; // R10
          ADDR_FREQ_HI: reg_rdata <= freq_pend_reg[TUNE_W-1:8]; // R10
          ADDR_RAW_COARSE: reg_rdata <= {16'h0, coarse_reg};
          ADDR_STATUS: reg_rdata <= {29'h0, cal_busy, coh_reg, pending_reg};
          ADDR_ACTIVE_LO: reg_rdata <= {24'h0, freq_act_reg[7:0]};
          ADDR_ACTIVE_HI: reg_rdata <= freq_act_reg[TUNE_W-1:8];
          default: reg_rdata <= 32'h0;
        endcase
      end
    end
  end
endmodule

// ### core/zoom_lo_pkg.sv
package zoom_lo_pkg;
  // Sample and phasor widths
  localparam int SAMPLE_W = 16;
  localparam int PHASOR_W = 16;
  // Tuning word: fine step is fs/1.024e12, so 2^40 steps per fs is about that resolution
  localparam int TUNE_W = 40;
  // Raw path: coarse in fs/2048 units, fine in fs/1.024e12 units
  localparam int COARSE_W = 16;
  localparam int FINE_W = 32;
  localparam int COARSE_SHIFT = 29; // 2^40 / 2048
  // Fine scaling: word = fine * 2^40 / 1.024e12, approximated as fine * 1100 >> 10
  localparam int FINE_MUL = 1100;
  localparam int FINE_SHIFT = 10;
  // Register offsets
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_FREQ_LO = 4'h1;
  localparam logic [3:0] ADDR_FREQ_HI = 4'h2;
  localparam logic [3:0] ADDR_RAW_COARSE = 4'h3;
  localparam logic [3:0] ADDR_RAW_FINE = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h5;
  localparam logic [3:0] ADDR_ACTIVE_LO = 4'h6;
  localparam logic [3:0] ADDR_ACTIVE_HI = 4'h7;
  // Control fields
  localparam int CTRL_CMPLX_BIT = 0;
  localparam int CTRL_SYNC_BIT = 1;
  localparam int CTRL_CAL_BIT = 2;
  // Status fields
  localparam int STAT_PEND_BIT = 0;
  localparam int STAT_COH_BIT = 1;
  localparam int STAT_ABORT_BIT = 2;
  // Reset values and FIFO depth
  localparam logic [TUNE_W-1:0] FREQ_RESET = 40'h0;
  localparam int FIFO_DEPTH = 8;
  // Calibration run length in sample clocks
  localparam int CAL_CYCLES = 64;
endpackage

// ### testbench/testbench.sv
`timescale 1ns/1ps
module testbench
  import zoom_lo_pkg::*;
;
  logic sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, sync_pin = 1'b0;
  logic meas_active = 1'b0, sample_valid = 1'b0, bb_ready = 1'b1, clk_en = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, bb_data, ref0, got;
  logic [SAMPLE_W-1:0] sample_in = 16'h1000;
  logic sample_ready, bb_valid, meas_abort, lo_coherent;
  int bad_count = 0, cmp_count = 0, cyc = 0, aborts = 0, n, m;
  zoom_lo_frequency_control zoom_lo_frequency_control_inst (.sys_clk(sys_clk), .rst(rst),
    .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sync_pin(sync_pin), .meas_active(meas_active),
    .sample_in(sample_in), .sample_valid(sample_valid), .sample_ready(sample_ready),
    .bb_data(bb_data), .bb_valid(bb_valid), .bb_ready(bb_ready), .meas_abort(meas_abort),
    .lo_coherent(lo_coherent));
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Cycle ceiling well above the few hundred cycles the tests need
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    aborts <= aborts + int'(meas_abort === 1'b1);
    if (cyc == 6000) begin
      bad_count++;
      test_done();
    end
  end
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    // Idle edge so a following write never re-drives the strobe in the same step
    @(posedge sys_clk);
  endtask
  // Read data are taken at the edge after the strobe, before that edge clears them
  task automatic rc(input logic [3:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    chk(reg_rdata, e);
  endtask
  // Low byte first, the high write commits the word
  task automatic wf(input logic [39:0] w);
    wr(ADDR_FREQ_LO, {24'h0, w[7:0]});
    wr(ADDR_FREQ_HI, w[39:8]);
  endtask
  task automatic cf(input logic [3:0] a, input logic [39:0] w);
    rc(a, {24'h0, w[7:0]});
    rc(a + 4'h1, w[39:8]);
  endtask
  task automatic xs(output logic [31:0] o);
    sample_valid <= 1'b1;
    @(posedge sys_clk);
    while (sample_ready !== 1'b1) @(posedge sys_clk);
    sample_valid <= 1'b0;
    @(posedge sys_clk);
    while (bb_valid !== 1'b1) @(posedge sys_clk);
    o = bb_data;
  endtask
  task automatic sync_pulse();
    sync_pin <= 1'b1;
    repeat (8) @(posedge sys_clk);
    sync_pin <= 1'b0;
    @(posedge sys_clk);
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rc(ADDR_CTRL, 32'h0);
    cf(ADDR_FREQ_LO, 40'h0);
    rc(ADDR_STATUS, 32'h2);
    rc(4'h9, 32'h0);
    $display("test reset done");
    xs(ref0);
    // Phase zero: I is the sample times a full-scale cosine, Q is zero
    chk(ref0, 32'h0fff0000);
    // Stall the far side, fill until refused, then drain
    n = 0;
    m = 0;
    bb_ready <= 1'b0;
    sample_valid <= 1'b1;
    repeat (20) begin
      @(posedge sys_clk);
      n += int'(sample_ready === 1'b1);
    end
    sample_valid <= 1'b0;
    bb_ready <= 1'b1;
    repeat (30) begin
      @(posedge sys_clk);
      if (bb_valid === 1'b1) chk(bb_data, ref0);
      m += int'(bb_valid === 1'b1);
    end
    chk(32'(n >= FIFO_DEPTH), 32'h1);
    chk(32'(m), 32'(n));
    $display("test stream done");
    wf(40'h1234567834);
    cf(ADDR_FREQ_LO, 40'h1234567834);
    cf(ADDR_ACTIVE_LO, 40'h1234567834);
    wf(40'hc000000000);
    cf(ADDR_ACTIVE_LO, 40'hc000000000);
    wf(40'h4000000000);
    wf(40'h0);
    xs(got);
    chk(got, ref0);
    wr(ADDR_CTRL, 32'h1);
    wf(40'h4000000000);
    wf(40'h0);
    xs(got);
    chk(32'(got !== ref0), 32'h1);
    $display("test phase done");
    wr(ADDR_CTRL, 32'h2);
    wf(40'h0800000000);
    rc(ADDR_STATUS, 32'h3);
    cf(ADDR_ACTIVE_LO, 40'h0);
    cf(ADDR_FREQ_LO, 40'h0800000000);
    sync_pulse();
    cf(ADDR_ACTIVE_LO, 40'h0800000000);
    wf(40'h0100000000);
    wr(ADDR_CTRL, 32'h0);
    cf(ADDR_ACTIVE_LO, 40'h0100000000);
    wr(ADDR_RAW_COARSE, 32'h200);
    wr(ADDR_RAW_FINE, 32'h400);
    cf(ADDR_ACTIVE_LO, 40'h400000044c);
    // A write while the clock enable is low must leave every word untouched
    clk_en <= 1'b0;
    wf(40'h0300000000);
    clk_en <= 1'b1;
    cf(ADDR_ACTIVE_LO, 40'h400000044c);
    cf(ADDR_FREQ_LO, 40'h400000044c);
    $display("test tuning done");
    meas_active <= 1'b1;
    wr(ADDR_CTRL, 32'h4);
    repeat (80) @(posedge sys_clk);
    rc(ADDR_STATUS, 32'h0);
    chk(32'(aborts), 32'h1);
    wr(ADDR_CTRL, 32'h2);
    wf(40'h0200000000);
    sync_pulse();
    rc(ADDR_STATUS, 32'h2);
    chk(32'(aborts), 32'h1);
    $display("test calibration done");
    test_done();
  end
endmodule

// ### testbench/zoom_lo_frequency_control_props.sv
`timescale 1ns/1ps
module zoom_lo_frequency_control_props
  import zoom_lo_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic sync_pin,
  input wire logic meas_active,
  input wire logic [SAMPLE_W-1:0] sample_in,
  input wire logic sample_valid,
  input wire logic sample_ready,
  input wire logic [2*SAMPLE_W-1:0] bb_data,
  input wire logic bb_valid,
  input wire logic bb_ready,
  input wire logic meas_abort,
  input wire logic lo_coherent
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic cal_wr;
  // Calibration start seen on the register port
  assign cal_wr = reg_wr && reg_addr == ADDR_CTRL && reg_wdata[CTRL_CAL_BIT];
  rd_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data without a read");
  unmapped_a: assert property (reg_rd && reg_addr > ADDR_ACTIVE_HI |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  abort_pulse_a: assert property (meas_abort |=> !meas_abort)
    else $error("abort longer than one cycle");
  abort_cause_a: assert property (meas_abort |->
    $past(cal_wr && meas_active) || $past(cal_wr && meas_active, 2))
    else $error("abort without calibration");
  ready_cal_a: assert property (cal_wr |-> ##3 (!sample_ready) [*8])
    else $error("samples taken during calibration");
  coh_lost_a: assert property (cal_wr |-> ##[1:3] !lo_coherent)
    else $error("coherence kept after calibration");
  bb_hold_a: assert property (bb_valid && !bb_ready |=> bb_valid)
    else $error("output dropped while stalled");
  bb_stable_a: assert property (bb_valid && !bb_ready |=> $stable(bb_data))
    else $error("output changed while stalled");
endmodule
bind zoom_lo_frequency_control zoom_lo_frequency_control_props zoom_lo_frequency_control_props_inst (.*);
